// file: rtl/card_host_pkg.sv
package card_host_pkg;

  // Register offsets on the peripheral bus
  localparam logic [7:0] OFS_POWER  = 8'h00;
  localparam logic [7:0] OFS_CLOCK  = 8'h04;
  localparam logic [7:0] OFS_ARG    = 8'h08;
  localparam logic [7:0] OFS_CMD    = 8'h0C;
  localparam logic [7:0] OFS_DCTRL  = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [7:0] OFS_CLEAR  = 8'h38;
  localparam logic [7:0] OFS_MASK   = 8'h3C;

  // Reset values and writable bits
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam logic [31:0] CLOCK_MASK  = 32'h0000_7FFF;
  localparam logic [31:0] CMD_MASK    = 32'h0000_7FFF;
  localparam logic [31:0] DCTRL_MASK  = 32'h0000_0FFF;
  localparam logic [1:0]  POWER_ON    = 2'h3;

  // Status flag positions
  localparam int unsigned ATA_DONE_BIT = 23;
  localparam int unsigned SDIO_IRQ_BIT = 22;

  // Bus width encodings and the lines they use
  localparam logic [1:0] WIDTH_ONE   = 2'h0;
  localparam logic [1:0] WIDTH_FOUR  = 2'h1;
  localparam logic [1:0] WIDTH_EIGHT = 2'h2;
  localparam logic [7:0] LINES_ONE   = 8'h01;
  localparam logic [7:0] LINES_FOUR  = 8'h0F;
  localparam logic [7:0] LINES_EIGHT = 8'hFF;

  // Timing in card bit cycles
  localparam logic [1:0] READ_WAIT_DELAY = 2'h2;
  localparam logic [3:0] DISABLE_DELAY   = 4'h8;
  localparam logic [5:0] DISABLE_LOAD    = 6'h2B;
  localparam logic [5:0] DISABLE_END     = 6'h30;
  localparam logic [4:0] DISABLE_PATTERN = 5'h01;
  localparam logic [2:0] GUARD_BITS      = 3'h7;
  localparam logic [2:0] PUSH_BITS       = 3'h5;

  typedef struct packed {
    logic [16:0] reserved;
    logic        flow_control_enable;
    logic        falling_edge;
    logic [1:0]  bus_width_select;
    logic        bypass;
    logic        idle_clock_gating;
    logic        card_clock_gate;
    logic [7:0]  clock_divide_factor;
  } clock_ctrl_t;

  typedef struct packed {
    logic [16:0] reserved;
    logic        ata_command_flag;
    logic        device_interrupt_disable;
    logic        completion_signal_enable;
    logic        suspend_command_flag;
    logic        command_enable;
    logic        wait_pending;
    logic        wait_interrupt;
    logic [1:0]  wait_response;
    logic [5:0]  command_index;
  } command_t;

  typedef struct packed {
    logic [19:0] reserved;
    logic        sdio_enable;
    logic        wait_by_clock_stop;
    logic        read_wait_stop;
    logic        read_wait_start;
    logic [3:0]  block_size;
    logic        dma_enable;
    logic        stream_mode;
    logic        read_direction;
    logic        data_enable;
  } data_control_t;

  // Events from the framing and FIFO logic beside this block
  typedef struct packed {
    logic resp_short_done;
    logic resp_accepted;
    logic rx_block_end;
    logic tx_crc_token;
    logic rx_packet_done;
    logic transfer_done;
    logic rx_fifo_empty;
    logic rx_fifo_full;
    logic tx_fifo_empty;
  } core_events_t;

  typedef enum logic [5:0] {
    cmd_idle      = 6'h01,
    cmd_wait_resp = 6'h02,
    cmd_pend      = 6'h04,
    cmd_send_dis  = 6'h08,
    cmd_wait_cpl  = 6'h10,
    cmd_guard     = 6'h20
  } cmd_state_t;

  typedef enum logic [5:0] {
    dp_idle     = 6'h01,
    dp_send     = 6'h02,
    dp_wait_r   = 6'h04,
    dp_rw_count = 6'h08,
    dp_rw_halt  = 6'h10,
    dp_drain    = 6'h20
  } dp_state_t;

endpackage : card_host_pkg

// file: rtl/card_host_special_ops.sv
`timescale 1ns/10ps
// How it works
// - Clock-stop read wait halts card clock two bit cycles after block end; start resumes.
// - Commands may go out during read wait; data line one interrupts still detected.
// - Accepted suspend response during a write makes data path idle after the current CRC token.
// - Clearing data enable during a write sends the data path idle.
// - Read suspend waits for packet end, then idles once the receive FIFO empties.
// - Data line one interrupts are detected only with the SD I/O enable bit set.
// - Completion handling applies only when the ATA command flag is set.
// - Completion disable is sent eight bit cycles after a short response.
// - Pending loads pattern 00001 and count 43; send; idle at count 48.
// - Completion enable plus interrupt disable waits for completion on the command line.
// - A zero ends the wait; seven bit cycles blocked, last five driven high.
// - Completion sets sticky status bit 23, cleared by clear bit 23, masked onto interrupt.
// - Clearing command enable aborts without sending the completion disable.
// - Flow control halts card clock and freezes machines; register bus keeps working.
// - Flow control is enabled only by clock control bit 14; off after reset.
// - Power field 11 clocks the card; other codes keep its clock stopped.
// - Clock control bit 13 picks rising or falling kernel clock edge; bypass ignores it.
// - Bus width field selects one, four or eight data lines.
// - Bypass passes kernel clock; otherwise divide by factor plus two.
// - Clock gate and idle gating control the card clock, except during read wait.
module card_host_special_ops
  import card_host_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Peripheral bus
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Card pins
  output logic                       card_bus_clock,
  input  wire logic                  card_cmd_in,
  output logic                       card_cmd_out,
  output logic                       card_cmd_oe_n,
  input  wire logic                  card_data_line_one,
  // Neighbouring framing and FIFO logic
  input  wire core_events_t          events,
  output logic                       command_issue,
  output logic      [31:0]           command_argument_value,
  output logic      [7:0]            data_lines_used,
  output logic                       card_tick,
  output logic                       interrupt_request
);

  logic [1:0]    power_state_field;
  clock_ctrl_t   clock_control_reg;
  command_t      command_reg;
  data_control_t data_control_reg;
  logic [1:0]    interrupt_mask_reg;
  logic          ata_done_flag;
  logic          sdio_irq_flag;
  cmd_state_t    cmd_state;
  dp_state_t     dp_state;
  logic          suspend_ack;
  logic          stall;
  logic          run;
  logic          div_clk;
  logic          neg_clk;
  logic [8:0]    div_count;
  logic [5:0]    bit_count;
  logic [4:0]    shifter;
  logic [3:0]    pend_count;
  logic [2:0]    guard_count;
  logic [1:0]    rw_count;
  logic          cmd_meta;
  logic          cmd_sync;
  logic          d1_meta;
  logic          d1_sync;
  logic          write_access;
  logic          mapped;
  logic          cmd_write;
  logic          dctrl_write;
  logic          rw_start_write;
  logic [31:0]   next_prdata;
  logic          next_div_clk;
  logic          busy;

  // Bus decode; every access completes at once
  assign pready       = 1'b1;
  assign write_access = psel && penable && pwrite;

  always_comb begin
    mapped      = 1'b1;
    next_prdata = RESET_WORD;
    if (paddr == ADDR_WIDTH'(OFS_POWER)) begin
      next_prdata = {30'h0000_0000, power_state_field};
    end else if (paddr == ADDR_WIDTH'(OFS_CLOCK)) begin
      next_prdata = clock_control_reg;
    end else if (paddr == ADDR_WIDTH'(OFS_ARG)) begin
      next_prdata = command_argument_value;
    end else if (paddr == ADDR_WIDTH'(OFS_CMD)) begin
      next_prdata = command_reg;
    end else if (paddr == ADDR_WIDTH'(OFS_DCTRL)) begin
      next_prdata = data_control_reg;
    end else if (paddr == ADDR_WIDTH'(OFS_STATUS)) begin
      next_prdata[ATA_DONE_BIT] = ata_done_flag;
      next_prdata[SDIO_IRQ_BIT] = sdio_irq_flag;
    end else if (paddr == ADDR_WIDTH'(OFS_CLEAR)) begin
      next_prdata = RESET_WORD;
    end else if (paddr == ADDR_WIDTH'(OFS_MASK)) begin
      next_prdata[ATA_DONE_BIT] = interrupt_mask_reg[1];
      next_prdata[SDIO_IRQ_BIT] = interrupt_mask_reg[0];
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr        = psel && penable && !mapped;
  assign cmd_write      = write_access && paddr == ADDR_WIDTH'(OFS_CMD);
  assign dctrl_write    = write_access && paddr == ADDR_WIDTH'(OFS_DCTRL);
  assign rw_start_write = dctrl_write && pwdata[8];

  // Read data captured in the setup phase so it is stable in the access phase
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= RESET_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Register writes stay live during a stall, so software can service the FIFO
  always_ff @(posedge clock) begin
    if (reset) begin
      power_state_field      <= RESET_WORD[1:0];
      clock_control_reg      <= clock_ctrl_t'(RESET_WORD);
      command_argument_value <= RESET_WORD;
      command_reg            <= command_t'(RESET_WORD);
      data_control_reg       <= data_control_t'(RESET_WORD);
      interrupt_mask_reg     <= RESET_WORD[1:0];
    end else if (write_access) begin
      if (paddr == ADDR_WIDTH'(OFS_POWER)) begin
        power_state_field <= pwdata[1:0];
      end else if (paddr == ADDR_WIDTH'(OFS_CLOCK)) begin
        clock_control_reg <= clock_ctrl_t'(pwdata & CLOCK_MASK);
      end else if (paddr == ADDR_WIDTH'(OFS_ARG)) begin
        command_argument_value <= pwdata;
      end else if (paddr == ADDR_WIDTH'(OFS_CMD)) begin
        command_reg <= command_t'(pwdata & CMD_MASK);
      end else if (paddr == ADDR_WIDTH'(OFS_DCTRL)) begin
        data_control_reg <= data_control_t'(pwdata & DCTRL_MASK);
      end else if (paddr == ADDR_WIDTH'(OFS_MASK)) begin
        interrupt_mask_reg <= {pwdata[ATA_DONE_BIT], pwdata[SDIO_IRQ_BIT]};
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_meta <= 1'b1;
      cmd_sync <= 1'b1;
      d1_meta  <= 1'b1;
      d1_sync  <= 1'b1;
    end else begin
      cmd_meta <= card_cmd_in;
      cmd_sync <= cmd_meta;
      d1_meta  <= card_data_line_one;
      d1_sync  <= d1_meta;
    end
  end

  // Flow control stall and card clock run condition
  assign stall = clock_control_reg.flow_control_enable &&
                 ((dp_state == dp_send && events.tx_fifo_empty) ||
                  (dp_state == dp_wait_r && events.rx_fifo_full));
  assign busy  = cmd_state != cmd_idle || dp_state != dp_idle;
  assign run   = dp_state != dp_rw_halt && !stall &&
                 power_state_field == POWER_ON &&
                 clock_control_reg.card_clock_gate &&
                 (!clock_control_reg.idle_clock_gating || busy);

  // Divider: period is the factor plus two kernel cycles
  always_comb begin
    next_div_clk = 1'b0;
    if (run) begin
      next_div_clk = 9'(div_count) < ((9'(clock_control_reg.clock_divide_factor) + 9'h002) >> 1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      div_count <= 9'h000;
      div_clk   <= 1'b0;
    end else begin
      div_clk <= next_div_clk;
      if (!run || div_count == 9'(clock_control_reg.clock_divide_factor) + 9'h001) begin
        div_count <= 9'h000;
      end else begin
        div_count <= div_count + 9'h001;
      end
    end
  end

  // Half-cycle delayed copy for falling-edge generation
  always_ff @(negedge clock) begin
    if (reset) begin
      neg_clk <= 1'b0;
    end else begin
      neg_clk <= div_clk;
    end
  end

  assign card_tick = run && (clock_control_reg.bypass || div_count == 9'h000);

  // Bypass gates the kernel clock itself; glitch-free only if run changes while clock is low
  always_comb begin
    if (clock_control_reg.bypass) begin
      card_bus_clock = clock && run;
    end else if (clock_control_reg.falling_edge) begin
      card_bus_clock = neg_clk;
    end else begin
      card_bus_clock = div_clk;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      data_lines_used <= LINES_ONE;
    end else if (clock_control_reg.bus_width_select == WIDTH_EIGHT) begin
      data_lines_used <= LINES_EIGHT;
    end else if (clock_control_reg.bus_width_select == WIDTH_FOUR) begin
      data_lines_used <= LINES_FOUR;
    end else begin
      data_lines_used <= LINES_ONE;
    end
  end

  // Command path machine; commands may go out while read wait holds the data path
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_state     <= cmd_idle;
      command_issue <= 1'b0;
      bit_count     <= 6'h00;
      shifter       <= 5'h00;
      pend_count    <= 4'h0;
      guard_count   <= 3'h0;
    end else if (!stall) begin
      command_issue <= 1'b0;
      case (cmd_state)
        cmd_idle: begin
          if (cmd_write && pwdata[10]) begin
            command_issue <= 1'b1;
            if (pwdata[7:6] != 2'h0) begin
              cmd_state <= cmd_wait_resp;
            end
          end
        end
        cmd_wait_resp: begin
          if (!command_reg.command_enable) begin
            cmd_state <= cmd_idle;
          end else if (events.resp_short_done) begin
            if (command_reg.ata_command_flag && command_reg.device_interrupt_disable) begin
              if (command_reg.completion_signal_enable) begin
                cmd_state <= cmd_wait_cpl;
              end else begin
                cmd_state  <= cmd_pend;
                shifter    <= DISABLE_PATTERN;
                bit_count  <= DISABLE_LOAD;
                pend_count <= DISABLE_DELAY;
              end
            end else begin
              cmd_state <= cmd_idle;
            end
          end
        end
        cmd_pend: begin
          if (!command_reg.command_enable) begin
            cmd_state <= cmd_idle;
          end else if (card_tick) begin
            pend_count <= pend_count - 4'h1;
            if (pend_count == 4'h1) begin
              cmd_state <= cmd_send_dis;
            end
          end
        end
        cmd_send_dis: begin
          if (card_tick) begin
            shifter   <= {shifter[3:0], 1'b0};
            bit_count <= bit_count + 6'h01;
            if (bit_count + 6'h01 == DISABLE_END) begin
              cmd_state <= cmd_idle;
            end
          end
        end
        cmd_wait_cpl: begin
          if (!command_reg.command_enable) begin
            cmd_state <= cmd_idle;
          end else if (card_tick && !cmd_sync) begin
            cmd_state   <= cmd_guard;
            guard_count <= GUARD_BITS;
          end
        end
        cmd_guard: begin
          if (card_tick) begin
            guard_count <= guard_count - 3'h1;
            if (guard_count == 3'h1) begin
              cmd_state <= cmd_idle;
            end
          end
        end
        default: cmd_state <= cmd_idle;
      endcase
    end
  end

  // Command line drive: disable pattern, then the push-pull guard
  always_comb begin
    card_cmd_out  = 1'b1;
    card_cmd_oe_n = 1'b1;
    if (cmd_state == cmd_send_dis) begin
      card_cmd_out  = shifter[4];
      card_cmd_oe_n = 1'b0;
    end else if (cmd_state == cmd_guard && guard_count <= PUSH_BITS) begin
      card_cmd_oe_n = 1'b0;
    end
  end

  // Suspend acknowledge from the command path to the data path
  always_ff @(posedge clock) begin
    if (reset) begin
      suspend_ack <= 1'b0;
    end else if (cmd_state == cmd_wait_resp && events.resp_short_done &&
                 command_reg.suspend_command_flag && events.resp_accepted) begin
      suspend_ack <= 1'b1;
    end else if (dp_state == dp_idle) begin
      suspend_ack <= 1'b0;
    end
  end

  // Data path machine; the remaining block count is not kept across suspend
  always_ff @(posedge clock) begin
    if (reset) begin
      dp_state <= dp_idle;
      rw_count <= 2'h0;
    end else if (!stall) begin
      case (dp_state)
        dp_idle: begin
          if (dctrl_write && pwdata[0]) begin
            dp_state <= pwdata[1] ? dp_wait_r : dp_send;
          end
        end
        dp_send: begin
          if (!data_control_reg.data_enable || events.transfer_done) begin
            dp_state <= dp_idle;
          end else if (suspend_ack && events.tx_crc_token) begin
            dp_state <= dp_idle;
          end
        end
        dp_wait_r: begin
          if (!data_control_reg.data_enable || events.transfer_done) begin
            dp_state <= dp_idle;
          end else if (suspend_ack && events.rx_packet_done) begin
            dp_state <= dp_drain;
          end else if (events.rx_block_end && data_control_reg.sdio_enable &&
                       data_control_reg.wait_by_clock_stop) begin
            dp_state <= dp_rw_count;
            rw_count <= READ_WAIT_DELAY;
          end
        end
        dp_rw_count: begin
          if (card_tick) begin
            rw_count <= rw_count - 2'h1;
            if (rw_count == 2'h1) begin
              dp_state <= dp_rw_halt;
            end
          end
        end
        dp_rw_halt: begin
          if (rw_start_write) begin
            dp_state <= dp_wait_r;
          end
        end
        dp_drain: begin
          if (events.rx_fifo_empty) begin
            dp_state <= dp_idle;
          end
        end
        default: dp_state <= dp_idle;
      endcase
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (reset) begin
      ata_done_flag <= 1'b0;
      sdio_irq_flag <= 1'b0;
    end else begin
      if (cmd_state == cmd_wait_cpl && command_reg.command_enable && !stall &&
          card_tick && !cmd_sync) begin
        ata_done_flag <= 1'b1;
      end else if (write_access && paddr == ADDR_WIDTH'(OFS_CLEAR) && pwdata[ATA_DONE_BIT]) begin
        ata_done_flag <= 1'b0;
      end
      if (data_control_reg.sdio_enable && !d1_sync &&
          (dp_state == dp_idle || dp_state == dp_rw_count || dp_state == dp_rw_halt)) begin
        sdio_irq_flag <= 1'b1;
      end else if (write_access && paddr == ADDR_WIDTH'(OFS_CLEAR) && pwdata[SDIO_IRQ_BIT]) begin
        sdio_irq_flag <= 1'b0;
      end
    end
  end

  assign interrupt_request = (ata_done_flag && interrupt_mask_reg[1]) ||
                             (sdio_irq_flag && interrupt_mask_reg[0]);

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_halt_no_tick:  assert property (dp_state == dp_rw_halt |-> !card_tick)
    else $error("card clock ticks during read wait halt");
  a_resume_start:  assert property (dp_state == dp_rw_halt && rw_start_write && !stall
                                    |=> dp_state == dp_wait_r)
    else $error("read wait start did not resume");
  a_suspend_idle:  assert property (dp_state == dp_send && data_control_reg.data_enable &&
                                    suspend_ack && events.tx_crc_token && !stall
                                    |=> dp_state == dp_idle)
    else $error("suspended write did not go idle");
  a_write_disable: assert property (dp_state == dp_send && !data_control_reg.data_enable
                                    && !stall |=> dp_state == dp_idle)
    else $error("cleared enable did not idle data path");
  a_drain_idle:    assert property (dp_state == dp_drain && events.rx_fifo_empty && !stall
                                    |=> dp_state == dp_idle)
    else $error("drained read suspend did not idle");
  a_sdio_gate:     assert property ($rose(sdio_irq_flag) |-> $past(data_control_reg.sdio_enable))
    else $error("interrupt flagged without enable");
  a_pend_load:     assert property ($rose(cmd_state == cmd_pend) |->
                                    bit_count == DISABLE_LOAD && shifter == DISABLE_PATTERN)
    else $error("pending state loaded wrongly");
  a_send_end:      assert property (cmd_state == cmd_send_dis && card_tick && !stall &&
                                    bit_count == DISABLE_END - 6'h01 |=> cmd_state == cmd_idle)
    else $error("disable send did not end at count");
  a_guard_push:    assert property (cmd_state == cmd_guard && guard_count <= PUSH_BITS
                                    |-> !card_cmd_oe_n && card_cmd_out)
    else $error("guard cycles not driven high");
  a_done_cause:    assert property ($rose(ata_done_flag) |-> $past(cmd_state == cmd_wait_cpl))
    else $error("completion flag without wait");
  a_stall_stop:    assert property (stall |-> !card_tick ##1 (!card_tick || !stall))
    else $error("card clock runs during flow stall");

  c_read_wait:  cover property (dp_state == dp_rw_count ##[1:40] dp_state == dp_rw_halt);
  c_disable:    cover property (cmd_state == cmd_pend ##[1:300] cmd_state == cmd_send_dis);
  c_completion: cover property (cmd_state == cmd_wait_cpl ##[1:300] cmd_state == cmd_guard);
  c_suspend:    cover property (suspend_ack && dp_state == dp_send ##[1:300] dp_state == dp_idle);

endmodule : card_host_special_ops

// file: test/card_model.sv
`timescale 1ns/10ps
module card_model (
  // Host side of the command line
  input  wire logic cmd_out,
  input  wire logic cmd_oe_n,
  // Bench requests
  input  wire logic cpl_req,
  input  wire logic irq_req,
  // Lines seen by the host
  output logic      cmd_line,
  output logic      d1_line
);
  // Both lines carry pull-ups, so released means high
  assign cmd_line = (cmd_oe_n | cmd_out) & !cpl_req;
  assign d1_line  = !irq_req;
endmodule : card_model

// file: test/tb_card_host_special_ops.sv
`timescale 1ns/10ps
module tb_card_host_special_ops;
  import card_host_pkg::*;
  logic         clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic         cpl = 0, irq = 0, cmd_in, d1, cmd_out, oe_n, ck, issue, tick, intr, rdy;
  logic [7:0]   paddr = 8'h00, lines;
  logic [31:0]  pwdata = 32'h0, prdata, d, arg;
  core_events_t ev = '0;
  int           mismatches = 0, cmp_count = 0, n, m;
  always #4 clock = ~clock;
  card_host_special_ops dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy),
    .pslverr(err), .card_bus_clock(ck), .card_cmd_in(cmd_in), .card_cmd_out(cmd_out),
    .card_cmd_oe_n(oe_n), .card_data_line_one(d1), .events(ev), .command_issue(issue),
    .command_argument_value(arg), .data_lines_used(lines), .card_tick(tick),
    .interrupt_request(intr));
  card_model card (.cmd_out(cmd_out), .cmd_oe_n(oe_n), .cpl_req(cpl), .irq_req(irq),
    .cmd_line(cmd_in), .d1_line(d1));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(negedge clock); psel = 1; pwrite = w; paddr = a; pwdata = wd;
    @(negedge clock); penable = 1;
    @(posedge clock); d = prdata; n = err; chk(rdy, 1);
    @(negedge clock); psel = 0; penable = 0;
  endtask : bus
  task resp;
    @(negedge clock); ev.resp_short_done = 1; ev.resp_accepted = 1;
    @(negedge clock); ev = '0;
  endtask : resp
  // Samples first, then drives the held events for the next edge
  task count(input int cyc, input core_events_t hold);
    n = 0;
    m = 0;
    repeat (cyc) begin @(negedge clock); n += tick; m += ck; ev = hold; end
  endtask : count
  task t_regs;
    int i;
    bus(0, OFS_POWER, 0); chk(d, RESET_WORD);
    bus(0, OFS_CLOCK, 0); chk(d, RESET_WORD);
    bus(1, OFS_ARG, 32'hA5C3_0F96); chk(arg, 32'hA5C3_0F96);
    bus(1, OFS_CLOCK, 32'hFFFF_FFFF); bus(0, OFS_CLOCK, 0); chk(d, CLOCK_MASK);
    for (i = 0; i < 3; i++) begin
      bus(1, OFS_CLOCK, 32'(i) << 11); repeat (3) @(negedge clock);
      chk(lines, i == 0 ? LINES_ONE : i == 1 ? LINES_FOUR : LINES_EIGHT);
    end
    bus(0, 8'h40, 0); chk(n, 1);
    // No identification phase here, so the fastest divided rate, half the kernel clock, is allowed
    bus(1, OFS_CLOCK, 32'h0000_0100);
    count(40, '0); chk(n, 0);
    bus(1, OFS_POWER, 32'h3); count(40, '0); chk(n, 20);
  endtask : t_regs
  // Idle gating makes the tick count show whether the data path is busy
  task t_data;
    bus(1, OFS_MASK, 32'h0040_0000); bus(1, OFS_CLOCK, 32'h0000_0300);
    count(20, '0); chk(n, 0);
    bus(1, OFS_DCTRL, 32'h0000_0C03); count(20, '0); chk(n, 10);
    chk(m, 10);
    @(negedge clock); ev.rx_block_end = 1; count(20, '0); chk(n, 2);
    chk(ck, 0);
    irq = 1; repeat (4) @(negedge clock); chk(intr, 1);
    irq = 0; bus(1, OFS_CLEAR, 32'h0040_0000); chk(intr, 0);
    bus(1, OFS_CMD, 32'h0000_0400); chk(issue, 1);
    bus(1, OFS_DCTRL, 32'h0000_0D03); count(20, '0); chk(n, 10);
    chk(m, 10);
    bus(1, OFS_CMD, 32'h0000_0C40); resp();
    @(negedge clock); ev.rx_packet_done = 1; count(10, '0); chk(n, 5);
    @(negedge clock); ev.rx_fifo_empty = 1; count(10, '0); chk(n, 0);
    bus(1, OFS_CLOCK, 32'h0000_4300); bus(1, OFS_DCTRL, 32'h0000_0001);
    @(negedge clock); ev.tx_fifo_empty = 1; count(10, 9'h001); chk(n, 0);
    bus(1, OFS_ARG, 32'h0F0F_1234); ev = '0; chk(arg, 32'h0F0F_1234);
    count(10, '0); chk(n, 5);
    bus(1, OFS_CMD, 32'h0000_0C40); resp(); count(10, '0); chk(n, 5);
    @(negedge clock); ev.tx_crc_token = 1; count(10, '0); chk(n, 0);
    bus(1, OFS_DCTRL, 32'h0000_0001); bus(1, OFS_DCTRL, 32'h0000_0000);
    count(10, '0); chk(n, 0);
    irq = 1; repeat (5) @(negedge clock); chk(intr, 0);
    irq = 0;
  endtask : t_data
  task t_disable;
    logic [4:0] v;
    bus(1, OFS_CMD, 32'h0000_647D); resp();
    for (n = 0; oe_n && n < 200; n++) @(negedge clock);
    v = 5'h1F;
    for (n = 0; !oe_n && n < 50; n++) begin
      if (tick) v = {v[3:0], cmd_out};
      @(negedge clock);
    end
    chk(v, 5'h01);
  endtask : t_disable
  task t_complete;
    bus(1, OFS_MASK, 32'h0080_0000); bus(1, OFS_CMD, 32'h0000_747D); resp();
    repeat (30) @(negedge clock);
    chk(intr, 0);
    cpl = 1;
    for (n = 0; !intr && n < 50; n++) @(negedge clock);
    cpl = 0;
    chk(intr, 1);
    for (n = 0; oe_n && n < 50; n++) @(negedge clock);
    chk({oe_n, cmd_out}, 2'b01);
    bus(0, OFS_STATUS, 0); chk(d[23], 1);
    bus(1, OFS_CLEAR, 32'h0080_0000); bus(0, OFS_STATUS, 0); chk(d[23], 0);
  endtask : t_complete
  task quiet(input logic [31:0] cmd, input logic abort, output int low);
    bus(1, OFS_CMD, cmd); resp();
    if (abort) bus(1, OFS_CMD, 0);
    low = 0;
    repeat (100) begin @(negedge clock); low += !oe_n; end
  endtask : quiet
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    int q;
    repeat (16) @(negedge clock);
    reset = 0;
    t_regs();
    t_disable();
    t_complete();
    quiet(32'h0000_247D, 0, q); chk(q, 0);
    quiet(32'h0000_647D, 1, q); chk(q, 0);
    t_data();
    test_done();
  end
  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    test_done();
  end
endmodule : tb_card_host_special_ops
